// *** hdl/fdcd_pkg.sv ***
// Constants for the floppy controller command decoder.
`default_nettype none
package fdcd_pkg;
  // Command opcodes, low five bits unless noted.
  localparam logic [4:0] OP_RECAL    = 5'h07;
  localparam logic [4:0] OP_SENSE_INT = 5'h08;
  localparam logic [4:0] OP_SPECIFY  = 5'h03;
  localparam logic [4:0] OP_SENSE_DRV = 5'h04;
  localparam logic [4:0] OP_SEEK     = 5'h0f;
  localparam logic [4:0] OP_CONFIGURE = 5'h13;
  localparam logic [4:0] OP_DUMP     = 5'h0e;
  localparam logic [4:0] OP_READ_ID  = 5'h0a;
  localparam logic [4:0] OP_PERP     = 5'h12;
  localparam logic [4:0] OP_LOCK     = 5'h14;
  localparam logic [4:0] OP_FORMAT   = 5'h0d;
  localparam logic [4:0] OP_READ     = 5'h06;
  localparam logic [4:0] OP_WRITE    = 5'h05;
  localparam int         MFM_BIT     = 6;
  // Configure byte field positions.
  localparam int         CFG_EIS_BIT   = 6;
  localparam int         CFG_FIFO_BIT  = 5;
  localparam int         CFG_POLL_BIT  = 4;
  // AXI4-Lite register byte offsets.
  localparam logic [7:0] REG_DATA    = 8'h00;
  localparam logic [7:0] REG_MSR     = 8'h04;
  localparam logic [7:0] REG_IRQ_ST  = 8'h08;
  localparam logic [7:0] REG_IRQ_MSK = 8'h0c;
  localparam logic [7:0] REG_SETUP   = 8'h10;
  localparam logic [7:0] REG_DRV     = 8'h14;
  localparam logic [7:0] REG_SEEKST  = 8'h18;
  // Reset value and status bytes.
  localparam logic [7:0] CFG_RESET   = 8'h20;
  localparam logic [7:0] INVALID_ST0 = 8'h80;
  localparam logic [7:0] SEEK_ERR_ST0 = 8'h70;
  // Step timing: one step per 3 ms.
  localparam int         STEP_US     = 3000;
  localparam int         CLK_MHZ     = 25;
  localparam int         STEP_CYC    = STEP_US * CLK_MHZ;
  localparam int         MAX_RESULT  = 10;
  typedef enum logic [2:0] {
    FDCD_IDLE, FDCD_PARAM, FDCD_EXEC, FDCD_RESULT
  } fdcd_state_e;
endpackage
`default_nettype wire

// *** hdl/fdcd_decoder.sv ***
// Floppy controller command decoder for non-data commands, AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module fdcd_decoder #(
  parameter int STEP_CYCLES = fdcd_pkg::STEP_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  drive_state_in,
  input  wire logic        id_valid,
  input  wire logic [31:0] id_info,
  input  wire logic        data_cmd_start,
  output logic             step_pulse,
  output logic             step_dir_in,
  output logic             seek_fail,
  output logic             irq
);
  import fdcd_pkg::*;

  fdcd_state_e      state_q;
  logic [4:0]       op_q;
  logic             mfm_q, lock_q, last_fmt_q, seek_done, bad_op;
  logic [3:0]       pcnt_q, need_q, rlen_q, ridx_q, busy_q;
  logic [7:0]       prm_q [0:2];
  logic [7:0]       res_q [0:MAX_RESULT-1];
  logic [7:0]       cyl_q [0:3];
  logic [7:0]       cfg_q, spec1_q, spec2_q, perp_q, sc_q, eot_q, precomp_start_track_q, target_q, st0_q;
  logic [1:0]       sdrv_q, irq_st_q, irq_msk_q;
  logic [31:0]      stepc_q;
  // Drive state pins come from the drive, so they pass two flip-flops first.
  logic [3:0]       dsi_meta_q, dsi_q;

  // AXI write channel: address and data taken in either order.
  logic             aw_got_q, w_got_q;
  logic [7:0]       awa_q;
  logic [31:0]      wd_q;
  logic             wr_go;
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign wr_go = aw_got_q && w_got_q;
  assign s_axi_bresp = 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wd_q <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                               {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic             data_wr, data_rd;
  assign data_wr = wr_go && awa_q == REG_DATA;
  assign data_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == REG_DATA;

  // Parameter count per opcode; invalid opcodes take none.
  function automatic logic [3:0] param_count(input logic [4:0] op);
    case (op)
      OP_RECAL, OP_SENSE_DRV, OP_READ_ID, OP_PERP: param_count = 4'd1;
      OP_SPECIFY, OP_SEEK: param_count = 4'd2;
      OP_CONFIGURE: param_count = 4'd3;
      default: param_count = 4'd0;
    endcase
  endfunction

  function automatic logic valid_op(input logic [7:0] b);
    case (b[4:0])
      OP_RECAL, OP_SENSE_INT, OP_SPECIFY, OP_SENSE_DRV, OP_CONFIGURE,
      OP_DUMP, OP_PERP, OP_LOCK: valid_op = b[7:5] == 3'h0 || b[4:0] == OP_LOCK;
      OP_SEEK: valid_op = b[7:5] == 3'h0;
      OP_READ_ID: valid_op = b[7] == 1'b0 && b[5] == 1'b0;
      default: valid_op = 1'b0;
    endcase
  endfunction

  assign bad_op = !valid_op(wd_q[7:0]);
  assign seek_done = state_q == FDCD_EXEC && cyl_q[sdrv_q] == target_q
                     && op_q == OP_SEEK && pcnt_q == 4'h0;

  // Command sequencer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= FDCD_IDLE;
      op_q <= 5'h00;
      mfm_q <= 1'b0;
      pcnt_q <= 4'h0;
      need_q <= 4'h0;
      rlen_q <= 4'h0;
      ridx_q <= 4'h0;
      sdrv_q <= 2'h0;
      target_q <= 8'h00;
      st0_q <= 8'h00;
      for (int i = 0; i < 3; i++) prm_q[i] <= 8'h00;
      for (int i = 0; i < MAX_RESULT; i++) res_q[i] <= 8'h00;
    end else begin
      case (state_q)
        FDCD_IDLE: begin
          if (data_wr) begin
            op_q <= wd_q[4:0];
            mfm_q <= wd_q[MFM_BIT];
            pcnt_q <= 4'h0;
            if (bad_op) begin
              res_q[0] <= INVALID_ST0;
              rlen_q <= 4'd1;
              ridx_q <= 4'd0;
              state_q <= FDCD_RESULT;
            end else begin
              need_q <= param_count(wd_q[4:0]);
              state_q <= param_count(wd_q[4:0]) == 4'd0 ? FDCD_EXEC : FDCD_PARAM;
            end
          end else if (data_cmd_start && cfg_q[CFG_EIS_BIT]) begin
            op_q <= OP_SEEK;
            pcnt_q <= 4'h0;
            sdrv_q <= id_info[25:24];
            target_q <= id_info[23:16];
            state_q <= FDCD_EXEC;
          end
        end
        FDCD_PARAM: begin
          if (data_wr) begin
            prm_q[pcnt_q[1:0]] <= wd_q[7:0];
            pcnt_q <= pcnt_q + 4'd1;
            if (pcnt_q + 4'd1 == need_q) state_q <= FDCD_EXEC;
          end
        end
        FDCD_EXEC: begin
          ridx_q <= 4'd0;
          case (op_q)
            OP_RECAL: begin
              sdrv_q <= prm_q[0][1:0];
              target_q <= 8'h00;
              op_q <= OP_SEEK;
              pcnt_q <= 4'h0;
              st0_q <= {6'h08, prm_q[0][1:0]};
            end
            OP_SEEK: begin
              if (pcnt_q != 4'h0) begin
                sdrv_q <= prm_q[0][1:0];
                target_q <= prm_q[1];
                st0_q <= {5'h04, prm_q[0][2:0]};
                pcnt_q <= 4'h0;
              end else if (seek_done) begin
                rlen_q <= 4'd0;
                state_q <= FDCD_IDLE;
              end
            end
            OP_SENSE_INT: begin
              res_q[0] <= st0_q;
              res_q[1] <= cyl_q[sdrv_q];
              rlen_q <= 4'd2;
              state_q <= FDCD_RESULT;
            end
            OP_SENSE_DRV: begin
              res_q[0] <= {dsi_q, 1'b0, prm_q[0][2:0]};
              rlen_q <= 4'd1;
              state_q <= FDCD_RESULT;
            end
            OP_DUMP: begin
              for (int i = 0; i < 4; i++) res_q[i] <= cyl_q[i];
              res_q[4] <= spec1_q;
              res_q[5] <= spec2_q;
              res_q[6] <= last_fmt_q ? sc_q : eot_q;
              res_q[7] <= {lock_q, perp_q[6:0]};
              res_q[8] <= cfg_q;
              res_q[9] <= precomp_start_track_q;
              rlen_q <= 4'd10;
              state_q <= FDCD_RESULT;
            end
            OP_READ_ID: begin
              if (id_valid) begin
                res_q[0] <= {5'h00, prm_q[0][2:0]};
                res_q[1] <= 8'h00;
                res_q[2] <= {7'h00, mfm_q};
                for (int i = 0; i < 4; i++) res_q[3+i] <= id_info[8*(3-i)+:8];
                rlen_q <= 4'd7;
                state_q <= FDCD_RESULT;
              end
            end
            OP_LOCK: begin
              res_q[0] <= {3'h0, lock_q, 4'h0};
              rlen_q <= 4'd1;
              state_q <= FDCD_RESULT;
            end
            default: begin
              rlen_q <= 4'd0;
              state_q <= FDCD_IDLE;
            end
          endcase
        end
        FDCD_RESULT: begin
          if (data_rd) begin
            ridx_q <= ridx_q + 4'd1;
            if (ridx_q + 4'd1 >= rlen_q) state_q <= FDCD_IDLE;
          end
        end
        default: state_q <= FDCD_IDLE;
      endcase
    end
  end

  // Settings written by specify, configure, perpendicular, lock and the setup register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RESET;
      spec1_q <= 8'h00;
      spec2_q <= 8'h00;
      perp_q <= 8'h00;
      lock_q <= 1'b0;
      sc_q <= 8'h00;
      eot_q <= 8'h00;
      precomp_start_track_q <= 8'h00;
      last_fmt_q <= 1'b0;
    end else begin
      if (state_q == FDCD_EXEC) begin
        if (op_q == OP_CONFIGURE) begin
          cfg_q <= {1'b0, prm_q[1][6:0]};
          precomp_start_track_q <= prm_q[2];
        end
        if (op_q == OP_SPECIFY) begin
          spec1_q <= prm_q[0];
          spec2_q <= prm_q[1];
        end
        if (op_q == OP_PERP) perp_q <= prm_q[0];
      end
      if (state_q == FDCD_IDLE && data_wr && wd_q[4:0] == OP_LOCK) lock_q <= wd_q[7];
      if (wr_go && awa_q == REG_SETUP) begin
        last_fmt_q <= wd_q[16];
        sc_q <= wd_q[7:0];
        eot_q <= wd_q[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    dsi_meta_q <= drive_state_in;
    dsi_q <= dsi_meta_q;
  end

  // Head stepping; busy while the drive moves.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) cyl_q[i] <= 8'h00;
      stepc_q <= 32'h0;
      busy_q <= 4'h0;
      step_pulse <= 1'b0;
      step_dir_in <= 1'b0;
    end else begin
      step_pulse <= 1'b0;
      busy_q <= 4'h0;
      if (state_q == FDCD_EXEC && op_q == OP_SEEK && pcnt_q == 4'h0 && !seek_done) begin
        busy_q[sdrv_q] <= 1'b1;
        if (stepc_q >= 32'(STEP_CYCLES - 1)) begin
          stepc_q <= 32'h0;
          step_pulse <= 1'b1;
          step_dir_in <= target_q > cyl_q[sdrv_q];
          if (target_q > cyl_q[sdrv_q]) cyl_q[sdrv_q] <= cyl_q[sdrv_q] + 8'd1;
          else cyl_q[sdrv_q] <= cyl_q[sdrv_q] - 8'd1;
        end else begin
          stepc_q <= stepc_q + 32'd1;
        end
      end else begin
        stepc_q <= 32'h0;
      end
    end
  end

  // Seek failure flag when the implied seek target is cylinder 8'hff.
  always_ff @(posedge aclk) begin
    if (!aresetn) seek_fail <= 1'b0;
    else if (state_q == FDCD_IDLE && data_cmd_start && cfg_q[CFG_EIS_BIT])
      seek_fail <= id_info[23:16] == 8'hff;
  end

  // Interrupts: bit 0 seek/recal done, bit 1 result ready. Set wins over clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= 2'h0;
      irq_msk_q <= 2'h0;
    end else begin
      if (wr_go && awa_q == REG_IRQ_MSK) irq_msk_q <= wd_q[1:0];
      irq_st_q <= (irq_st_q & ~((wr_go && awa_q == REG_IRQ_ST) ? wd_q[1:0] : 2'h0))
                  | {state_q == FDCD_EXEC && rlen_q != 4'd0 && 1'b0 || 
                     (state_q == FDCD_RESULT && ridx_q == 4'd0), seek_done};
    end
  end
  assign irq = |(irq_st_q & irq_msk_q);

  // Read channel, one cycle latency.
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        REG_DATA: s_axi_rdata <= state_q == FDCD_RESULT ? {24'h0, res_q[ridx_q]} : 32'h0;
        REG_MSR: s_axi_rdata <= {24'h0, state_q == FDCD_RESULT, state_q != FDCD_IDLE,
                                 2'h0, busy_q};
        REG_IRQ_ST: s_axi_rdata <= {30'h0, irq_st_q};
        REG_IRQ_MSK: s_axi_rdata <= {30'h0, irq_msk_q};
        REG_SEEKST: s_axi_rdata <= {24'h0, st0_q | (seek_fail ? SEEK_ERR_ST0 : 8'h00)};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  sequence seek_active_s;
    state_q == FDCD_EXEC && op_q == OP_SEEK && pcnt_q == 4'h0 && !seek_done;
  endsequence
  busy_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seek_active_s |=> busy_q[$past(sdrv_q)]) else $error("busy flag missing during seek");
  invalid_res_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == FDCD_IDLE && data_wr && bad_op |=> state_q == FDCD_RESULT && rlen_q == 4'd1)
    else $error("invalid opcode did not give one result byte");
  dump_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == FDCD_EXEC && op_q == OP_DUMP |=> rlen_q == 4'd10) else $error("dump length wrong");
  sense_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == FDCD_EXEC && op_q == OP_SENSE_INT |=> rlen_q == 4'd2) else $error("sense length");
  drive_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == FDCD_EXEC && op_q == OP_SENSE_DRV |=> rlen_q == 4'd1) else $error("drive status length");
  readid_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == FDCD_EXEC && op_q == OP_READ_ID && id_valid |=> rlen_q == 4'd7)
    else $error("read id length");
  recal_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == FDCD_EXEC && op_q == OP_RECAL |=> target_q == 8'h00 && op_q == OP_SEEK)
    else $error("recalibrate target not zero");
  cfg_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == FDCD_EXEC && op_q == OP_CONFIGURE |=> cfg_q[6:0] == $past(prm_q[1][6:0]) &&
    state_q == FDCD_IDLE) else $error("configure byte not stored");
  seek_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seek_done |=> state_q == FDCD_IDLE) else $error("seek did not finish");
endmodule
`default_nettype wire

// *** test/fdcd_host_model.sv ***
// Host processor model: an AXI4-Lite master that issues register cycles.
`timescale 1ns/1ps
`default_nettype none
module fdcd_host_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  input  wire logic [1:0]  bresp,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  logic [1:0]              wr_resp;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wr_resp = 2'h3;
  end
  // Address and data are offered together and each is dropped only once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        wr_resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// *** test/tb_floppy_ctrl_command_decoder.sv ***
// Self-checking testbench for the floppy controller command decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_floppy_ctrl_command_decoder;
  import fdcd_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, id_valid, data_cmd_start;
  logic        step_pulse, step_dir_in, irq, hd, sfail;
  logic [7:0]  awaddr, araddr, cyl, cfg, pre;
  logic [31:0] wdata, rdata, id_info, seed, got;
  logic [3:0]  wstrb, drive_state_in;
  logic [1:0]  rresp, resp, drv, bresp;
  logic [7:0]  present_cylinder [4];
  logic [7:0]  res [10];
  logic [7:0]  bad [3] = '{8'h00, 8'h01, 8'h1f};
  int          errors, n_checks, cyc, pos, p0, k;
  fdcd_decoder #(.STEP_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_state_in(drive_state_in),
    .id_valid(id_valid), .id_info(id_info), .data_cmd_start(data_cmd_start),
    .step_pulse(step_pulse), .step_dir_in(step_dir_in), .seek_fail(sfail), .irq(irq));
  fdcd_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bresp(bresp), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Net head position seen on the step outputs, inward counts up.
  always @(posedge aclk) begin
    cyc++;
    if (step_pulse) pos = step_dir_in ? pos + 1 : pos - 1;
    if (cyc == 60000) begin
      errors++;
      conclude();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic [7:0] b [$]);
    foreach (b[i]) host.wr(REG_DATA, {24'h0, b[i]});
  endtask
  task automatic rres(input int n);
    for (int i = 0; i < n; i++) begin
      host.rd(REG_DATA, got, resp);
      res[i] = got[7:0];
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    host.rd(a, got, resp);
    chk(got & m, e);
  endtask
  // Polls the seek-done flag, then clears it; a seek leaves no result bytes.
  task automatic wait_irq();
    got = '0;
    for (int i = 0; i < 400 && got[0] !== 1'b1; i++) host.rd(REG_IRQ_ST, got, resp);
    chk(got[0], 1'b1);
    rdchk(REG_MSR, 32'h80, 32'h0);
    host.wr(REG_IRQ_ST, 32'h1);
    got = '0;
  endtask
  task automatic sense(input logic [7:0] e);
    cmd('{{3'h0, OP_SENSE_INT}});
    rres(2);
    chk(res[1], e);
    rdchk(REG_MSR, 32'h80, 32'h0);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    seed = 32'h7388;
    {aresetn, id_valid, data_cmd_start, id_info, drive_state_in, got} = '0;
    present_cylinder = '{default: 8'h00};
    pos = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(REG_MSR, 32'hff, 32'h0);
    rdchk(8'h1c, 32'hffffffff, 32'h0);
    chk(resp, 2'b00);
    host.wr(8'h1c, 32'h1);
    chk(host.wr_resp, 2'b00);
    // Drive numbers are picked freely here; the model never touches select pins.
    for (k = 0; k < 3; k++) begin
      drv = 2'(xs());
      hd = seed[4];
      cyl = present_cylinder[drv] + 8'h1 + {5'h0, seed[7:5]};
      p0 = pos;
      cmd('{{3'h0, OP_SEEK}, {5'h0, hd, drv}, cyl});
      rdchk(REG_MSR, 32'h1 << drv, 32'h1 << drv);
      wait_irq();
      chk(pos - p0, cyl - present_cylinder[drv]);
      present_cylinder[drv] = cyl;
      sense(cyl);
    end
    p0 = pos;
    cmd('{{3'h0, OP_RECAL}, {6'h0, drv}});
    wait_irq();
    chk(p0 - pos, {24'h0, present_cylinder[drv]});
    present_cylinder[drv] = 8'h00;
    sense(8'h00);
    // Interrupt line must follow the mask while a seek-done flag is pending.
    cmd('{{3'h0, OP_SEEK}, {6'h0, drv}, 8'h02});
    present_cylinder[drv] = 8'h02;
    got = '0;
    for (int i = 0; i < 400 && got[0] !== 1'b1; i++) host.rd(REG_IRQ_ST, got, resp);
    host.wr(REG_IRQ_MSK, 32'h0);
    @(posedge aclk);
    hd = irq;
    host.wr(REG_IRQ_MSK, 32'h1);
    @(posedge aclk);
    chk(hd, 1'b0);
    chk(irq, 1'b1);
    host.wr(REG_IRQ_ST, 32'h1);
    rdchk(REG_IRQ_ST, 32'h1, 32'h0);
    @(posedge aclk);
    chk(irq, 1'b0);
    cfg = {1'b1, 7'(xs())} | 8'h40;
    pre = seed[15:8];
    cmd('{{3'h0, OP_CONFIGURE}, 8'h00, cfg & 8'h7f, pre});
    rdchk(REG_MSR, 32'h80, 32'h0);
    // Both settings of the last-command flag, so the count byte is seen in each meaning.
    for (k = 0; k < 2; k++) begin
      host.wr(REG_SETUP, {15'h0, k[0], 16'(xs())});
      cmd('{{3'h0, OP_DUMP}});
      rres(10);
      for (int i = 0; i < 4; i++) chk(res[i], present_cylinder[i]);
      chk(res[6], k[0] ? seed[7:0] : seed[15:8]);
      chk(res[8], cfg & 8'h7f);
      chk(res[9], pre);
      rdchk(REG_MSR, 32'h80, 32'h0);
    end
    drv = 2'(xs());
    cyl = present_cylinder[drv] + 8'h3;
    p0 = pos;
    id_info <= {6'h0, drv, cyl, 16'h0};
    data_cmd_start <= 1'b1;
    @(posedge aclk);
    data_cmd_start <= 1'b0;
    rdchk(REG_MSR, 32'h1 << drv, 32'h1 << drv);
    for (int i = 0; i < 400 && got[3:0] !== 4'h0; i++) host.rd(REG_MSR, got, resp);
    chk(pos - p0, 3);
    chk(sfail, 1'b0);
    present_cylinder[drv] = cyl;
    p0 = pos;
    id_info <= {6'h0, drv, 8'hff, 16'h0};
    data_cmd_start <= 1'b1;
    @(posedge aclk);
    data_cmd_start <= 1'b0;
    rdchk(REG_SEEKST, 32'h70, 32'h70);
    chk(sfail, 1'b1);
    got = '1;
    for (int i = 0; i < 1000 && got[3:0] !== 4'h0; i++) host.rd(REG_MSR, got, resp);
    chk(pos - p0, 255 - cyl);
    present_cylinder[drv] = 8'hff;
    for (k = 0; k < 4; k++) begin
      drive_state_in <= 4'(xs());
      hd = seed[9];
      cmd('{{3'h0, OP_SENSE_DRV}, {5'h0, hd, k[1:0]}});
      rres(1);
      chk({res[0][7:4], res[0][2:0]}, {drive_state_in, hd, k[1:0]});
      rdchk(REG_MSR, 32'h80, 32'h0);
    end
    foreach (bad[i]) begin
      cmd('{bad[i]});
      rres(1);
      chk(res[0], INVALID_ST0);
      rdchk(REG_MSR, 32'h80, 32'h0);
    end
    id_info <= xs();
    id_valid <= 1'b1;
    cmd('{{3'h2, OP_READ_ID}, {6'h0, drv}});
    rres(7);
    chk({res[3], res[4], res[5], res[6]}, id_info);
    chk(res[0][2:0], {1'b0, drv});
    rdchk(REG_MSR, 32'h80, 32'h0);
    id_valid <= 1'b0;
    conclude();
  end
endmodule
`default_nettype wire
